// File: core/apwt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module apwt_timer
    import apwt_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    // Autonomous oscillator clock pin
    input wire logic ACLK,
    // Nonvolatile trim value
    input wire logic [TRIM_W-1:0] NVM_TRIM,
    // Outputs
    output logic IRQ,
    output logic WAVE_PIN,
    output logic [TRIM_W-1:0] OSC_TRIM
);
    apwt_state_t state_r;
    apwt_ctl_t ctl_r;
    apwt_ctl_t wctl;
    logic [TRIM_W-1:0] trim_r;
    logic [RATE_W-1:0] period_rate_value_r;
    logic [RATE_W-1:0] cnt_r;
    logic half_r;
    logic pulse_r;
    logic sq_r;
    logic aclk_s1_r;
    logic aclk_s2_r;
    logic aclk_d_r;
    logic tick;
    logic timeout;
    logic wr_ctl;
    logic flag_clr;
    logic [DATA_W-1:0] rdata_r;
    logic irq_r;
    logic wave_r;

    assign wctl = apwt_ctl_t'(WDATA);
    assign wr_ctl = WR && (ADDR == CTL_ADDR);
    assign flag_clr = wr_ctl && wctl.timeout_flag;

    // Oscillator pin synchroniser, second stage feeds edge detect
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aclk_s1_r <= 1'b0;
            aclk_s2_r <= 1'b0;
            aclk_d_r <= 1'b0;
        end else begin
            aclk_s1_r <= ACLK;
            aclk_s2_r <= aclk_s1_r;
            aclk_d_r <= aclk_s2_r;
        end
    end

    assign tick = ctl_r.source_select_bit ? 1'b1 : (aclk_s2_r && !aclk_d_r);

    // period end when second half completes
    assign timeout = ctl_r.feature_enable_bit && tick
        && (cnt_r == period_rate_value_r) && half_r;

    // Trim load sequencer; one cycle after release
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= ST_LOAD;
        end else begin
            case (state_r)
                ST_LOAD: state_r <= ST_RUN;
                ST_RUN: state_r <= ST_RUN;
                default: state_r <= ST_LOAD;
            endcase
        end
    end

    // Trim register, written any time after the load
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trim_r <= TRIM_RST;
        end else if (state_r == ST_LOAD) begin
            trim_r <= NVM_TRIM;
        end else if (WR && (ADDR == TRIM_ADDR)) begin
            trim_r <= WDATA[TRIM_W-1:0];
        end
    end

    // Control register; the flag lives here too so ctl_r has one driver
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_r.source_select_bit <= CTL_RST[SRC_POS];
            ctl_r.rsv <= 2'h0;
            ctl_r.waveform_select_bit <= CTL_RST[WAVE_POS];
            ctl_r.external_output_enable <= CTL_RST[EXT_POS];
            ctl_r.feature_enable_bit <= CTL_RST[FE_POS];
            ctl_r.timeout_irq_enable <= CTL_RST[IE_POS];
            ctl_r.timeout_flag <= CTL_RST[FLAG_POS];
        end else begin
            // write-one clear; a coinciding time-out wins
            ctl_r.timeout_flag <= timeout || (ctl_r.timeout_flag && !flag_clr);
            if (wr_ctl) begin
                // source select locked while running or enabling
                if (!ctl_r.feature_enable_bit && !wctl.feature_enable_bit) begin
                    ctl_r.source_select_bit <= wctl.source_select_bit;
                end
                ctl_r.waveform_select_bit <= wctl.waveform_select_bit;
                ctl_r.external_output_enable <= wctl.external_output_enable;
                ctl_r.feature_enable_bit <= wctl.feature_enable_bit;
                ctl_r.timeout_irq_enable <= wctl.timeout_irq_enable;
            end
        end
    end

    // full 16-bit rate reaches the longest period
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            period_rate_value_r <= RATE_RST;
        end else if (WR && !ctl_r.feature_enable_bit) begin
            if (ADDR == RATEH_ADDR) begin
                period_rate_value_r[15:8] <= WDATA;
            end
            if (ADDR == RATEL_ADDR) begin
                period_rate_value_r[7:0] <= WDATA;
            end
        end
    end

    // Half-period counter; two halves make one period
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_r <= RATE_RST;
            half_r <= 1'b0;
        end else if (!ctl_r.feature_enable_bit) begin
            cnt_r <= RATE_RST;
            half_r <= 1'b0;
        end else if (tick) begin
            // rate plus one ticks per half
            if (cnt_r == period_rate_value_r) begin
                cnt_r <= RATE_RST;
                half_r <= !half_r;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Waveform sources; pulse lasts one tick, half the shortest period
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pulse_r <= 1'b0;
            sq_r <= 1'b0;
        end else if (!ctl_r.feature_enable_bit) begin
            pulse_r <= 1'b0;
            sq_r <= 1'b0;
        end else begin
            if (timeout) begin
                pulse_r <= 1'b1;
            end else if (tick) begin
                pulse_r <= 1'b0;
            end
            if (timeout) begin
                sq_r <= !sq_r;
            end
        end
    end

    // Pin and interrupt are registered so outputs come from flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wave_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            wave_r <= ctl_r.external_output_enable && ctl_r.feature_enable_bit
                && (ctl_r.waveform_select_bit ? sq_r : pulse_r);
            irq_r <= ctl_r.timeout_flag && ctl_r.timeout_irq_enable;
        end
    end

    // Read port; data valid only the cycle after the strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                CTL_ADDR: rdata_r <= {ctl_r[7], 2'b00, ctl_r[4:0]};
                TRIM_ADDR: rdata_r <= {2'b00, trim_r};
                RATEH_ADDR: rdata_r <= period_rate_value_r[15:8];
                RATEL_ADDR: rdata_r <= period_rate_value_r[7:0];
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign RDATA = rdata_r;
    assign IRQ = irq_r;
    assign WAVE_PIN = wave_r;
    // top bit lengthens, lower bits shorten in halving steps
    assign OSC_TRIM = trim_r;

    // Cycle counter for period checks, bus clock only
    logic [CYC_W-1:0] cyc_r;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cyc_r <= 18'h00000;
        end else if (!ctl_r.feature_enable_bit || timeout) begin
            cyc_r <= 18'h00000;
        end else begin
            cyc_r <= cyc_r + 18'h00001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    AST_SRC_LOCK: assert property (
        (ctl_r.feature_enable_bit || (wr_ctl && wctl.feature_enable_bit))
            |=> $stable(ctl_r.source_select_bit))
        else $error("source select changed while enabled");

    AST_RATE_LOCK: assert property (
        ctl_r.feature_enable_bit |=> $stable(period_rate_value_r))
        else $error("rate changed while enabled");

    AST_STOPPED: assert property (
        !ctl_r.feature_enable_bit |=> !timeout && cnt_r == 16'h0000 && !half_r)
        else $error("timer active while disabled");

    AST_FLAG_SET: assert property (
        timeout |=> ctl_r.timeout_flag)
        else $error("flag not set on time-out");

    AST_FLAG_HOLD: assert property (
        ctl_r.timeout_flag && !flag_clr |=> ctl_r.timeout_flag)
        else $error("flag lost without write-one");

    AST_FLAG_CLR: assert property (
        flag_clr && !timeout |=> !ctl_r.timeout_flag)
        else $error("flag not cleared by write-one");

    AST_IRQ_ON: assert property (
        ctl_r.timeout_flag && ctl_r.timeout_irq_enable |=> IRQ)
        else $error("interrupt missing");

    AST_IRQ_OFF: assert property (
        !ctl_r.timeout_irq_enable |=> !IRQ)
        else $error("interrupt while disabled");

    AST_PIN_GATE: assert property (
        !(ctl_r.external_output_enable && ctl_r.feature_enable_bit) |=> !WAVE_PIN)
        else $error("pin driven while gated");

    AST_PULSE: assert property (
        timeout && !ctl_r.waveform_select_bit && ctl_r.external_output_enable
            ##1 ctl_r.feature_enable_bit && ctl_r.external_output_enable
            && !ctl_r.waveform_select_bit |=> WAVE_PIN)
        else $error("pulse missing at period end");

    AST_SQ_TOGGLE: assert property (
        timeout |=> sq_r != $past(sq_r))
        else $error("square wave did not toggle");

    AST_BUS_PERIOD: assert property (
        timeout && ctl_r.source_select_bit
            |-> ({2'b00, cyc_r} + 20'h00001) == ({3'b000, period_rate_value_r, 1'b0}
            + 20'h00002))
        else $error("bus clock period wrong");

    AST_BUS_RANGE: assert property (
        timeout && ctl_r.source_select_bit
            |-> cyc_r >= CYC_W'(BUS_MIN_PERIOD - 1) && cyc_r <= CYC_W'(BUS_MAX_PERIOD - 1))
        else $error("bus clock period out of range");

    AST_TRIM_LOAD: assert property (
        state_r == ST_LOAD && RESET_N |=> trim_r == $past(NVM_TRIM))
        else $error("trim not loaded after reset");

    AST_RESTART: assert property (
        timeout ##1 ctl_r.feature_enable_bit |-> cnt_r == 16'h0000 && !half_r)
        else $error("counter did not restart");

    COV_BUS_TIMEOUT: cover property (
        timeout && ctl_r.source_select_bit);
    COV_OSC_TIMEOUT: cover property (
        timeout && !ctl_r.source_select_bit);
    COV_SET_CLR_CLASH: cover property (
        timeout && flag_clr);
    COV_SQ_PIN: cover property (
        ctl_r.waveform_select_bit && $rose(WAVE_PIN));
endmodule : apwt_timer
`default_nettype wire

// File: core/apwt_pkg.sv
package apwt_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int TRIM_W = 6;
    localparam int RATE_W = 16;
    // Byte addresses of the four registers
    localparam logic [ADDR_W-1:0] CTL_ADDR = 10'h2F2;
    localparam logic [ADDR_W-1:0] TRIM_ADDR = 10'h2F3;
    localparam logic [ADDR_W-1:0] RATEH_ADDR = 10'h2F4;
    localparam logic [ADDR_W-1:0] RATEL_ADDR = 10'h2F5;
    // Control field positions
    localparam int SRC_POS = 7;
    localparam int WAVE_POS = 4;
    localparam int EXT_POS = 3;
    localparam int FE_POS = 2;
    localparam int IE_POS = 1;
    localparam int FLAG_POS = 0;
    // Reset values
    localparam logic [DATA_W-1:0] CTL_RST = 8'h00;
    localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;
    localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;
    // Bus clock period limits in bus cycles
    localparam int BUS_MIN_PERIOD = 2;
    localparam int BUS_MAX_PERIOD = 131072;
    localparam int CYC_W = 18;

    typedef struct packed {
        logic source_select_bit;
        logic [1:0] rsv;
        logic waveform_select_bit;
        logic external_output_enable;
        logic feature_enable_bit;
        logic timeout_irq_enable;
        logic timeout_flag;
    } apwt_ctl_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } apwt_state_t;
endpackage : apwt_pkg

// File: tb/apwt_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module apwt_osc_model
    import apwt_pkg::*;
#(
    parameter int HALF_NS = 20,
    parameter logic [TRIM_W-1:0] TRIM_VAL = 6'h2A
) (
    // Oscillator pin and trim store
    output logic aclk,
    output logic [TRIM_W-1:0] nvm_trim
);
    // Free-running oscillator, phase kept clear of bus clock edges
    initial begin
        aclk = 1'b0;
        #1.3;
        forever #(HALF_NS) aclk = ~aclk;
    end

    // Stored trim, offered steadily so the post-reset load sees it
    assign nvm_trim = TRIM_VAL;
endmodule : apwt_osc_model
`default_nettype wire

// File: tb/apwt_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module apwt_timer_tb_top
    import apwt_pkg::*;
();
    localparam logic [TRIM_W-1:0] NVM_VAL = 6'h2A;
    logic clk;
    logic reset_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] rdata;
    logic aclk;
    logic [TRIM_W-1:0] nvm_trim;
    logic irq;
    logic wave_pin;
    logic [TRIM_W-1:0] osc_trim;
    int fails;
    int total_checks;
    int w;
    int p;

    // Bus clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Oscillator period of ten bus cycles keeps tick counts exact
    apwt_osc_model #(.HALF_NS(20), .TRIM_VAL(NVM_VAL)) apwt_osc_model_i (
        .aclk(aclk), .nvm_trim(nvm_trim));

    apwt_timer apwt_timer_i (
        .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ACLK(aclk), .NVM_TRIM(nvm_trim), .IRQ(irq), .WAVE_PIN(wave_pin),
        .OSC_TRIM(osc_trim));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic chk_n(input string what, input int e, input int g);
        total_checks++;
        if (g != e) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_n

    // One-cycle write strobe, taken at the following edge
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data only stands in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, e, rdata);
    endtask : rd_chk

    // Edges until irq (sel 0) or the pin (sel 1) reaches lvl; 300 means never
    task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (((sel == 0) ? irq : wave_pin) !== lvl && cnt < 300);
    endtask : wait_lvl

    // Rise, then width of the high phase and of the low phase
    task automatic pulse_meas(output int hi, output int lo);
        int n;
        wait_lvl(1, 1'b1, n);
        wait_lvl(1, 1'b0, hi);
        wait_lvl(1, 1'b1, lo);
    endtask : pulse_meas

    initial begin
        reset_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(CTL_ADDR, 8'h00, "control reset");
        rd_chk(TRIM_ADDR, {2'b00, NVM_VAL}, "trim load");
        rd_chk(RATEH_ADDR, 8'h00, "rate high reset");
        wr_reg(10'h2F6, 8'h5A);
        rd_chk(10'h2F6, 8'h00, "unmapped");
        wr_reg(TRIM_ADDR, 8'hFF);
        rd_chk(TRIM_ADDR, 8'h3F, "trim write");
        chk("trim out", 8'h3F, {2'b00, osc_trim});
        $display("test registers done");
        // Enabling in the same write must not move the source select
        wr_reg(RATEH_ADDR, 8'h12);
        wr_reg(RATEL_ADDR, 8'h34);
        wr_reg(CTL_ADDR, 8'hE4);
        rd_chk(CTL_ADDR, 8'h04, "source with enable");
        wr_reg(RATEL_ADDR, 8'h03);
        wr_reg(RATEH_ADDR, 8'h00);
        rd_chk(RATEH_ADDR, 8'h12, "rate high locked");
        rd_chk(RATEL_ADDR, 8'h34, "rate low locked");
        wr_reg(CTL_ADDR, 8'h00);
        wr_reg(CTL_ADDR, 8'h80);
        rd_chk(CTL_ADDR, 8'h80, "source when off");
        wr_reg(RATEH_ADDR, 8'h00);
        wr_reg(RATEL_ADDR, 8'h03);
        $display("test protection done");
        // Rate 3 on bus clock: flag 8 cycles after the enable edge, irq one later;
        // counting starts one edge after that enable edge
        wr_reg(CTL_ADDR, 8'h86);
        wait_lvl(0, 1'b1, w);
        chk_n("irq delay", 2 * (3 + 1) + 1, w);
        wr_reg(CTL_ADDR, 8'h82);
        rd_chk(CTL_ADDR, 8'h83, "flag write zero");
        chk("irq held", 8'h01, {7'h00, irq});
        wr_reg(CTL_ADDR, 8'h81);
        rd_chk(CTL_ADDR, 8'h80, "flag cleared");
        chk("irq gone", 8'h00, {7'h00, irq});
        wr_reg(CTL_ADDR, 8'h84);
        repeat (30) @(posedge clk);
        #1;
        chk("irq masked", 8'h00, {7'h00, irq});
        rd_chk(CTL_ADDR, 8'h85, "flag set");
        // Disable mid-period, then a full period must follow
        wr_reg(CTL_ADDR, 8'h81);
        wr_reg(CTL_ADDR, 8'h84);
        repeat (3) @(posedge clk);
        wr_reg(CTL_ADDR, 8'h80);
        wr_reg(CTL_ADDR, 8'h86);
        wait_lvl(0, 1'b1, w);
        chk_n("restart delay", 2 * (3 + 1) + 1, w);
        wr_reg(CTL_ADDR, 8'h81);
        $display("test flag done");
        // Pulse form at rates 0 and 5
        for (int r = 0; r <= 5; r += 5) begin
            wr_reg(RATEL_ADDR, r[7:0]);
            wr_reg(CTL_ADDR, 8'h8C);
            pulse_meas(w, p);
            chk_n("pulse width", 1, w);
            chk_n("pulse period", 2 * (r + 1), w + p);
            wr_reg(CTL_ADDR, 8'h81);
        end
        // Square form at rate 2 toggles every 6 cycles
        wr_reg(RATEL_ADDR, 8'h02);
        wr_reg(CTL_ADDR, 8'h9C);
        pulse_meas(w, p);
        chk_n("square high", 6, w);
        chk_n("square low", 6, p);
        wr_reg(CTL_ADDR, 8'h81);
        // Pin quiet unless both enables are set
        wr_reg(CTL_ADDR, 8'h94);
        wait_lvl(1, 1'b1, w);
        chk_n("pin without ext", 300, w);
        wr_reg(CTL_ADDR, 8'h81);
        wr_reg(CTL_ADDR, 8'h98);
        wait_lvl(1, 1'b1, w);
        chk_n("pin without enable", 300, w);
        $display("test waveform done");
        // Oscillator source, rate 0: two ticks of ten cycles
        wr_reg(CTL_ADDR, 8'h01);
        wr_reg(RATEL_ADDR, 8'h00);
        wr_reg(CTL_ADDR, 8'h0C);
        pulse_meas(w, p);
        chk_n("osc pulse width", 10, w);
        chk_n("osc period", 20, w + p);
        $display("test oscillator done");
        end_of_test();
    end

    // Tests need well under 10 us
    initial begin
        #40000;
        fails++;
        end_of_test();
    end
endmodule : apwt_timer_tb_top
`default_nettype wire
